/* hdl/dio_port.v */
`timescale 1ns/10ps
// Behaviour
// - Two byte ports, third split into nibbles
// - Line n maps data bit n, offsets 0-2
// - Offset 3 sets directions, 0 output
// - Bit 7 reads configuration source
// - Hardware source reads switch positions back
// - Switch-forced outputs ignore software direction
// - Output drives once direction write lands
// - Output port read returns driven value
// - Reset direction from switches, software, jumper
// - Retention jumper keeps port state over warm reset
// - Offset 32 control on write, status read
// - Bits 1:0 select interrupt source lines
// - Bit 2 picks rising or falling edge
// - Bit 3 reads pending interrupt flag
// - Writing one clears flag, zero ignored
// - No new interrupt while flag set
// - Offset 36 reads four-bit card identifier
`include "dio_map.vh"
module dio_port
(
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Host register port
  input wire [5:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Host interrupt request
  output reg irq_req,
  // Field lines, output enable active low
  input wire [7:0] first_byte_port_in,
  output reg [7:0] first_byte_port_out,
  output reg [7:0] first_byte_port_oe_n,
  input wire [7:0] second_byte_port_in,
  output reg [7:0] second_byte_port_out,
  output reg [7:0] second_byte_port_oe_n,
  input wire [7:0] third_byte_port_in,
  output reg [7:0] third_byte_port_out,
  output reg [7:0] third_byte_port_oe_n,
  // Board switches and jumper
  input wire [3:0] card_ident_switch_bank,
  input wire [5:0] direction_switch_bank,
  input wire hot_reset_retain_jumper,
  input wire power_on_rst
);
  // Direction bits: 1 input; order first, second, low nibble, high nibble
  reg [3:0] sw_dir;
  reg [7:0] data_first;
  reg [7:0] data_second;
  reg [7:0] data_third;
  reg [1:0] irq_source_sel;
  reg irq_edge_rise;
  reg irq_flag;
  reg warm;
  // Synchronisers for pins and switches
  reg [7:0] first_s1;
  reg [7:0] first_s2;
  reg [7:0] second_s1;
  reg [7:0] second_s2;
  reg [7:0] third_s1;
  reg [7:0] third_s2;
  reg [3:0] id_s1;
  reg [3:0] id_s2;
  reg [5:0] dsw_s1;
  reg [5:0] dsw_s2;
  reg [1:0] ctl_s1;
  reg [1:0] ctl_s2;
  wire config_source_indicator;
  wire [3:0] hw_dir;
  wire [3:0] eff_dir;
  wire edge_zero;
  wire edge_four;
  wire irq_event;
  wire flag_clear;
  wire retain;
  reg [7:0] next_rdata;

  // Merge input pins with driven outputs, per bit group
  function [7:0] dio_mix;
    input [7:0] pins;
    input [7:0] drv;
    input lo_in;
    input hi_in;
    begin
      dio_mix = {hi_in ? pins[7:4] : drv[7:4], lo_in ? pins[3:0] : drv[3:0]};
    end
  endfunction

  always @(posedge core_clk)
  begin
    first_s1 <= first_byte_port_in;
    first_s2 <= first_s1;
    second_s1 <= second_byte_port_in;
    second_s2 <= second_s1;
    third_s1 <= third_byte_port_in;
    third_s2 <= third_s1;
    id_s1 <= card_ident_switch_bank;
    id_s2 <= id_s1;
    dsw_s1 <= direction_switch_bank;
    dsw_s2 <= dsw_s1;
    ctl_s1 <= {power_on_rst, hot_reset_retain_jumper};
    ctl_s2 <= ctl_s1;
  end

  // Switch on means input; position 1 selects hardware source
  assign config_source_indicator = dsw_s2[`DIO_SWB_SRC];
  assign hw_dir = {dsw_s2[`DIO_SWB_HIGH_NIB], dsw_s2[`DIO_SWB_LOW_NIB],
                   dsw_s2[`DIO_SWB_SECOND], dsw_s2[`DIO_SWB_FIRST]};
  // In hardware mode a switch at output wins over software
  assign eff_dir = config_source_indicator ? (hw_dir & sw_dir) : sw_dir;

  // Retention only after a warm reset, never from power-up
  assign retain = ctl_s2[0] & warm & ~ctl_s2[1];

  dio_edge_detect u_edge_zero
  (
    .core_clk(core_clk),
    .srst(srst),
    .line_in(third_byte_port_in[0]),
    .rising_sel(irq_edge_rise),
    .edge_pulse(edge_zero)
  );

  dio_edge_detect u_edge_four
  (
    .core_clk(core_clk),
    .srst(srst),
    .line_in(third_byte_port_in[4]),
    .rising_sel(irq_edge_rise),
    .edge_pulse(edge_four)
  );

  assign irq_event = (irq_source_sel == `DIO_SRC_LINE0) ? edge_zero :
                     (irq_source_sel == `DIO_SRC_BOTH) ? (edge_zero | edge_four) :
                     1'b0;
  assign flag_clear = reg_wr && (reg_addr == `DIO_OFF_IRQ_CTL) &&
                      reg_wdata[`DIO_IRQ_FLAG];

  always @(posedge core_clk)
  begin
    if (srst)
    begin
      warm <= 1'b1;
      irq_source_sel <= `DIO_IRQ_RESET;
      irq_edge_rise <= 1'b0;
      irq_flag <= 1'b0;
      if (!retain)
      begin
        // Defaults are all inputs so nothing drives until told to
        sw_dir <= `DIO_DIR_RESET;
        data_first <= `DIO_DATA_RESET;
        data_second <= `DIO_DATA_RESET;
        data_third <= `DIO_DATA_RESET;
      end
    end
    else
    begin
      if (ctl_s2[1])
        warm <= 1'b0;
      else if (!warm)
        warm <= 1'b1;
      if (reg_wr)
      begin
        if (reg_addr == `DIO_OFF_PORT_FIRST)
          data_first <= reg_wdata;
        else if (reg_addr == `DIO_OFF_PORT_SECOND)
          data_second <= reg_wdata;
        else if (reg_addr == `DIO_OFF_PORT_THIRD)
          data_third <= reg_wdata;
        else if (reg_addr == `DIO_OFF_DIR_CFG)
          sw_dir <= {reg_wdata[`DIO_DIR_HIGH_NIB], reg_wdata[`DIO_DIR_LOW_NIB],
                     reg_wdata[`DIO_DIR_SECOND], reg_wdata[`DIO_DIR_FIRST]};
        else if (reg_addr == `DIO_OFF_IRQ_CTL)
        begin
          irq_source_sel <= reg_wdata[`DIO_IRQ_SEL_HI:`DIO_IRQ_SEL_LO];
          irq_edge_rise <= reg_wdata[`DIO_IRQ_EDGE];
        end
      end
      // Set wins over a clear in the same cycle; set flag blocks new ones
      if (irq_event && !irq_flag)
        irq_flag <= 1'b1;
      else if (flag_clear)
        irq_flag <= 1'b0;
    end
  end

  // Pins driven a cycle after the direction write lands
  always @(posedge core_clk)
  begin
    if (srst && !retain)
    begin
      first_byte_port_out <= `DIO_DATA_RESET;
      second_byte_port_out <= `DIO_DATA_RESET;
      third_byte_port_out <= `DIO_DATA_RESET;
      first_byte_port_oe_n <= 8'hff;
      second_byte_port_oe_n <= 8'hff;
      third_byte_port_oe_n <= 8'hff;
      irq_req <= 1'b0;
    end
    else
    begin
      first_byte_port_out <= data_first;
      second_byte_port_out <= data_second;
      third_byte_port_out <= data_third;
      first_byte_port_oe_n <= {8{eff_dir[0]}};
      second_byte_port_oe_n <= {8{eff_dir[1]}};
      third_byte_port_oe_n <= {{4{eff_dir[3]}}, {4{eff_dir[2]}}};
      irq_req <= srst ? 1'b0 : (irq_flag && (irq_source_sel != `DIO_SRC_OFF));
    end
  end

  always @*
  begin
    next_rdata = 8'h00;
    if (reg_addr == `DIO_OFF_PORT_FIRST)
      next_rdata = dio_mix(first_s2, data_first, eff_dir[0], eff_dir[0]);
    else if (reg_addr == `DIO_OFF_PORT_SECOND)
      next_rdata = dio_mix(second_s2, data_second, eff_dir[1], eff_dir[1]);
    else if (reg_addr == `DIO_OFF_PORT_THIRD)
      next_rdata = dio_mix(third_s2, data_third, eff_dir[2], eff_dir[3]);
    else if (reg_addr == `DIO_OFF_DIR_CFG)
    begin
      next_rdata[`DIO_DIR_SRC] = config_source_indicator;
      // Hardware mode reports switch positions, software mode the register
      next_rdata[`DIO_DIR_FIRST] = config_source_indicator ? hw_dir[0] : sw_dir[0];
      next_rdata[`DIO_DIR_SECOND] = config_source_indicator ? hw_dir[1] : sw_dir[1];
      // Hardware readback: bit 3 shows position 4, bit 0 position 6
      next_rdata[`DIO_DIR_LOW_NIB] = config_source_indicator ? hw_dir[3] : sw_dir[2];
      next_rdata[`DIO_DIR_HIGH_NIB] = config_source_indicator ? hw_dir[2] : sw_dir[3];
    end
    else if (reg_addr == `DIO_OFF_IRQ_CTL)
      next_rdata = {4'h0, irq_flag, irq_edge_rise, irq_source_sel};
    else if (reg_addr == `DIO_OFF_CARD_ID)
      next_rdata = {4'h0, id_s2};
  end

  always @(posedge core_clk)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end
endmodule // dio_port

/* hdl/dio_map.vh */
`ifndef DIO_MAP_VH
`define DIO_MAP_VH
// Register offsets (byte addresses)
`define DIO_OFF_PORT_FIRST 6'h00
`define DIO_OFF_PORT_SECOND 6'h01
`define DIO_OFF_PORT_THIRD 6'h02
`define DIO_OFF_DIR_CFG 6'h03
`define DIO_OFF_IRQ_CTL 6'h20
`define DIO_OFF_CARD_ID 6'h24
// Direction register fields
`define DIO_DIR_LOW_NIB 0
`define DIO_DIR_SECOND 1
`define DIO_DIR_HIGH_NIB 3
`define DIO_DIR_FIRST 4
`define DIO_DIR_SRC 7
// Direction switch bank positions (index 0 is position 1)
`define DIO_SWB_SRC 0
`define DIO_SWB_FIRST 2
`define DIO_SWB_LOW_NIB 3
`define DIO_SWB_SECOND 4
`define DIO_SWB_HIGH_NIB 5
// Interrupt register fields
`define DIO_IRQ_SEL_LO 0
`define DIO_IRQ_SEL_HI 1
`define DIO_IRQ_EDGE 2
`define DIO_IRQ_FLAG 3
// Source select codes
`define DIO_SRC_OFF 2'h0
`define DIO_SRC_LINE0 2'h1
`define DIO_SRC_BOTH 2'h2
// Reset values: all ports input, data zero, irq disabled
`define DIO_DIR_RESET 4'hf
`define DIO_DATA_RESET 8'h00
`define DIO_IRQ_RESET 2'h0
`endif

/* hdl/dio_edge_detect.v */
`timescale 1ns/10ps
// Two-flop synchroniser plus one stage for edge detection
module dio_edge_detect
(
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Line and edge select
  input wire line_in,
  input wire rising_sel,
  // Detected edge pulse
  output wire edge_pulse
);
  reg sync_a;
  reg sync_b;
  reg last;

  always @(posedge core_clk)
  begin
    if (srst)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      last <= 1'b0;
    end
    else
    begin
      sync_a <= line_in;
      sync_b <= sync_a;
      last <= sync_b;
    end
  end

  // One pulse per qualifying transition
  assign edge_pulse = rising_sel ? (sync_b & ~last) : (~sync_b & last);
endmodule // dio_edge_detect

/* test/dio_field_model.sv */
`timescale 1ns/10ps
module dio_field_model
(
  // Design side
  input wire [7:0] out,
  input wire [7:0] oe_n,
  // Field side
  input wire [7:0] drive,
  output wire [7:0] pin
);
  // Field drives only the lines that the port leaves undriven
  assign pin = (out & ~oe_n) | (drive & oe_n);
endmodule // dio_field_model

/* test/dio_port_assertions.sv */
`timescale 1ns/10ps
module dio_port_assertions
(
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Register port
  input wire [5:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire irq_req,
  // Pins and switches
  input wire [7:0] first_byte_port_oe_n,
  input wire [7:0] third_byte_port_oe_n,
  input wire [3:0] card_ident_switch_bank,
  input wire [5:0] direction_switch_bank
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  first_dir_a: assert property (reg_wr && reg_addr == 6'h03 && !direction_switch_bank[0]
    |-> ##2 first_byte_port_oe_n == {8{$past(reg_wdata[4], 2)}}) else $error("first dir");
  low_nib_a: assert property (reg_wr && reg_addr == 6'h03 && !direction_switch_bank[0]
    |-> ##2 third_byte_port_oe_n[3:0] == {4{$past(reg_wdata[0], 2)}}) else $error("low nib");
  card_id_a: assert property (reg_rd && reg_addr == 6'h24
    |=> reg_rdata[3:0] == $past(card_ident_switch_bank)) else $error("card id");
  unmapped_rd_a: assert property (reg_rd && reg_addr == 6'h10 |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata hold");
  irq_clear_a: assert property (reg_wr && reg_addr == 6'h20 && reg_wdata[3] && irq_req
    |-> ##2 !irq_req) else $error("irq clear");
  irq_off_a: assert property (reg_wr && reg_addr == 6'h20 && reg_wdata[1:0] == 2'h0
    |-> ##2 !irq_req [*2]) else $error("irq off");
  flag_read_a: assert property (reg_rd && reg_addr == 6'h20 && irq_req
    |=> reg_rdata[3]) else $error("flag read");
  hw_force_a: assert property (direction_switch_bank[0] && !direction_switch_bank[2]
    |=> first_byte_port_oe_n == 8'h00) else $error("hw force");
endmodule // dio_port_assertions
bind dio_port dio_port_assertions i_chk (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .irq_req, .first_byte_port_oe_n, .third_byte_port_oe_n,
  .card_ident_switch_bank, .direction_switch_bank);

/* test/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic core_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, jmp = 0, por = 1, x;
  logic [5:0] reg_addr = 0, dsw = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, d;
  logic irq_req;
  logic [3:0] id = 0;
  logic [7:0] pin [3], po [3], oe [3], fld [3];
  int fails = 0, checked = 0, seed = 40, i, s, e, l;
  int mdat [3], mdir [4];
  always #5 core_clk = ~core_clk;
  dio_port i_dut (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .irq_req, .first_byte_port_in(pin[0]), .first_byte_port_out(po[0]),
    .first_byte_port_oe_n(oe[0]), .second_byte_port_in(pin[1]), .second_byte_port_out(po[1]),
    .second_byte_port_oe_n(oe[1]), .third_byte_port_in(pin[2]), .third_byte_port_out(po[2]),
    .third_byte_port_oe_n(oe[2]), .card_ident_switch_bank(id), .direction_switch_bank(dsw),
    .hot_reset_retain_jumper(jmp), .power_on_rst(por));
  for (genvar g = 0; g < 3; g++)
  begin : g_fld
    dio_field_model i_fld (.out(po[g]), .oe_n(oe[g]), .drive(fld[g]), .pin(pin[g]));
  end
  task conclude;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] ex, input logic [7:0] got);
    checked++;
    if (got !== ex)
    begin
      $display("wrong value %s expected %h seen %h", n, ex, got);
      fails++;
    end
  endtask
  task wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [5:0] a, input logic [7:0] ex, input logic [7:0] m);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", ex & m, reg_rdata & m);
  endtask
  task rst(input logic [5:0] sw, input logic j, input logic p);
    // Straps settle through their synchronisers before reset samples them
    jmp <= j;
    por <= p;
    repeat (3) @(posedge core_clk);
    srst <= 1'b1;
    dsw <= sw;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
  endtask
  // Output bits read back the driven value, input bits the field
  function automatic logic [7:0] mport(int p);
    logic [7:0] m;
    m = p < 2 ? {8{1'(mdir[p])}} : {{4{1'(mdir[3])}}, {4{1'(mdir[2])}}};
    return (m & fld[p]) | (~m & 8'(mdat[p]));
  endfunction
  initial
  begin
    #200000 fails++;
    conclude;
  end
  initial
  begin
    for (i = 0; i < 3; i++) fld[i] = 8'h00;
    rst(6'h00, 1'b0, 1'b1);
    rd(6'h03, 8'h1b, 8'h9b);
    repeat (20)
    begin
      for (i = 0; i < 3; i++) mdat[i] = $random(seed) & 255;
      for (i = 0; i < 3; i++) wr(6'(i), 8'(mdat[i]));
      for (i = 0; i < 3; i++) fld[i] <= 8'($random(seed));
      d = 8'($random(seed));
      wr(6'h03, d);
      mdir = '{int'(d[4]), int'(d[1]), int'(d[0]), int'(d[3])};
      repeat (4) @(posedge core_clk);
      for (i = 0; i < 3; i++) rd(6'(i), mport(i), 8'hff);
      rd(6'h03, d & 8'h1b, 8'h9b);
      chk("first oe", {8{d[4]}}, oe[0]);
    end
    id <= 4'($random(seed));
    repeat (4) @(posedge core_clk);
    rd(6'h24, {4'h0, id}, 8'h0f);
    wr(6'h10, 8'hff);
    rd(6'h10, 8'h00, 8'hff);
    wr(6'h03, 8'h1b);
    for (s = 0; s < 4; s++)
      for (e = 0; e < 2; e++)
        for (l = 0; l < 8; l += 4)
        begin
          fld[2] <= {8{~1'(e)}};
          repeat (4) @(posedge core_clk);
          wr(6'h20, {4'h1, 1'(e), 2'(s)});
          fld[2][l] <= 1'(e);
          repeat (6) @(posedge core_clk);
          x = s == 2 || (s == 1 && l == 0);
          chk("irq", {7'h0, x}, {7'h0, irq_req});
          wr(6'h20, {4'h0, 1'(e), 2'(s)});
          rd(6'h20, {4'h0, x, 3'h0}, 8'h08);
          fld[2][l] <= ~1'(e);
          repeat (4) @(posedge core_clk);
          fld[2][l] <= 1'(e);
          repeat (6) @(posedge core_clk);
          wr(6'h20, {4'h1, 1'(e), 2'(s)});
          rd(6'h20, 8'h00, 8'h08);
        end
    rst(6'h09, 1'b0, 1'b0);
    rd(6'h03, 8'h88, 8'h9b);
    wr(6'h03, 8'hff);
    repeat (3) @(posedge core_clk);
    chk("forced oe", 8'h00, oe[0]);
    rst(6'h00, 1'b0, 1'b0);
    wr(6'h00, 8'h5a);
    wr(6'h03, 8'h0b);
    repeat (3) @(posedge core_clk);
    rst(6'h00, 1'b1, 1'b0);
    #1 chk("kept oe", 8'h00, oe[0]);
    chk("kept out", 8'h5a, po[0]);
    rst(6'h00, 1'b0, 1'b0);
    #1 chk("reset oe", 8'hff, oe[0]);
    conclude;
  end
endmodule // testbench
